// ===== hdl/crs_params.svh
// Purpose: constants of the reset, abort and single-step controller
// Assumes: 200 MHz sys_clk, byte addressed APB slave
// Notes:   definitions only
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
// ==========================================================
// register offsets
`define CRS_OFS_CTRL    12'h000
`define CRS_OFS_STATUS  12'h004
`define CRS_OFS_PTR     12'h008
`define CRS_OFS_PSW     12'h00c
`define CRS_OFS_PC      12'h010
`define CRS_OFS_SP      12'h014
// ==========================================================
// fields and values
`define CRS_CTRL_SWRST   0
`define CRS_CTRL_ALNANY  1
`define CRS_PSW_IBIT     0
`define CRS_CTX_VECTOR   32'h0000_0080
`define CRS_PSW_OFS      32'h0000_0000
`define CRS_PC_OFS       32'h0000_0004
`define CRS_SP_OFS       32'h0000_0008
`define CRS_PTR_STEP     32'h0000_000c
`define CRS_SAS_IDLE     4'hf
`define CRS_SAS_STOPACK  4'h0
`define CRS_XMD_KERNEL   2'h0
`define CRS_QS_IDLE      2'h3
// ==========================================================
// timing counts in clock cycles
`define CRS_RECOG_LATCH  3
`define CRS_STRETCH_CYC  128
`define CRS_VAD_CYC      66
`define CRS_XMD_CYC      18
`define CRS_ABT_DISC_CS  3'h4
`define CRS_ABT_ALIGN_CS 3'h3
`define CRS_ABT_LEN      3'h2
`endif

// ===== hdl/crs_pkg.sv
// Purpose: types of the reset, abort and single-step controller
// Assumes: used with crs_params.svh
// Notes:   state codes follow a Gray path
package crs_pkg;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_ACK    = 3'b000,
    ST_STRCH  = 3'b001,
    ST_LDPTR  = 3'b011,
    ST_LDPSW  = 3'b010,
    ST_LDPC   = 3'b110,
    ST_LDSP   = 3'b111,
    ST_RUN    = 3'b101
  } crs_state_e;
  typedef enum logic [1:0] {AB_NONE = 2'h0, AB_DISC = 2'h1, AB_ALIGN = 2'h2} crs_abort_e;
  // ==========================================================
  // requests of the execution core, one transfer start a pulse
  typedef struct packed {
    logic       txnStart;
    logic       discHit;
    logic       alignFault;
    logic       addrStrobeReq;
    logic       dataStrobeReq;
    logic       dataLatchReq;
    logic       rwReq;
    logic       cycleInitReq;
    logic [3:0] sasReq;
    logic [2:0] sizeReq;
    logic [1:0] queueReq;
    logic       soiReq;
    logic       vadReq;
    logic [1:0] xmdReq;
  } crs_core_s;
  // bus-side outputs, active-low pins end in B
  typedef struct packed {
    logic       resetAckB;
    logic       abortB;
    logic       addrStrobeB;
    logic       dataStrobeB;
    logic       dataLatchedB;
    logic       rwB;
    logic       cycleInitB;
    logic [3:0] accessStatusCode;
    logic [2:0] transferSize;
    logic [1:0] queueStatus;
    logic       instrStartB;
    logic       virtualAddrFlagB;
    logic [1:0] execModeOut;
    logic       busRequestLineB;
    logic       ctlOeB;
    logic       adOeB;
  } crs_bus_s;
  typedef struct packed {
    crs_state_e st;
    logic [2:0] hist;
    logic [7:0] cnt;
    logic [6:0] post;
    logic [31:0] ptr;
    logic [31:0] processor_status_word;
    logic [31:0] pc;
    logic [31:0] sp;
    logic       memReq;
    logic [31:0] memAddr;
    logic [2:0] cs;
    crs_abort_e amode;
    logic       ackMask;
    logic       alignTrap;
    crs_bus_s   bus;
    logic       soiPrev;
    logic       stopPrev;
    logic       spent;
    logic       halted;
    logic       intAckOk;
    logic       startAllowed;
    logic       alignAny;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
  } crs_all_s;
endpackage

// ===== hdl/crs_top.sv
// Purpose: reset handshake, context load, access abort and stop control
// Assumes: all inputs synchronous to sys_clk, APB register access
// Notes:   three-state pins are modelled by active-low enables
//
// Functional notes
// - three consecutive active reset latchings recognise reset
// - recognised reset: acknowledge and safe outputs
// - acknowledge held, then 128 cycles after negation
// - reset preempts every other activity
// - internal sequence starts in physical addressing
// - word at 0x80 loads the block pointer
// - status, pc, stack loaded from base offsets
// - initial-context bit set: clear it, pointer plus 12
// - internal reset also gives 128-cycle acknowledge
// - high-level bus fault causes simulated system reset
// - reset output states depend on arbiter role
// - physical flag after 66, kernel after 18 cycles; once in run, both follow the core requests instead
// - cache-hit discontinuity fetch aborts two cycles, state four
// - cancelled fetch: no strobes, acknowledges ignored
// - alignment fault aborts from state three, traps
// - stop halts after at most one more instruction
// - halted: bus grants yes, interrupts after release
// - halted shows stop acknowledge code when observable
// - at most one start pulse before stop acknowledge
// - start pulse lasts exactly one cycle
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_top
  import crs_pkg::*;
#(
  parameter int STRETCH_CYC = `CRS_STRETCH_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // system side
  input  wire logic        resetRequestInB,
  input  wire logic        faultResetReq,
  input  wire logic        arbiterSelectB,
  input  wire logic        busGrantAckB,
  input  wire logic        stopInB,
  output crs_bus_s         busOut,
  // execution core
  input  wire crs_core_s   coreReq,
  input  wire logic        coreInstrDone,
  output logic             startAllowed,
  output logic             intAckOk,
  output logic             ackMask,
  output logic             alignTrap,
  output logic             coreRun,
  output logic [31:0]      ctxPc,
  // context fetch port
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  output logic             memReq,
  output logic [31:0]      memAddr
);
  // ==========================================================
  // state register
  crs_all_s q;
  crs_all_s d;
  logic recog;
  logic reqNow;
  logic swRst;
  logic apbWr;
  logic stopNow;
  logic [2:0] csNext;
  crs_bus_s idleBus;
  logic [32:0] rdRes;

  // one flop stage per output, no glue after it except the coreRun state decode
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign busOut = q.bus;
  assign startAllowed = q.startAllowed;
  assign intAckOk = q.intAckOk;
  assign ackMask = q.ackMask;
  assign alignTrap = q.alignTrap;
  assign coreRun = (q.st == ST_RUN);
  assign ctxPc = q.pc;
  assign memReq = q.memReq;
  assign memAddr = q.memAddr;

  // register read decode, used by read data and error answer
  function automatic logic [32:0] rdDecode(input logic [11:0] a, input crs_all_s s);
    logic [32:0] r;
    r = {1'b0, 32'h0};
    unique case (a)
      `CRS_OFS_CTRL:   r = {1'b0, 30'h0, s.alignAny, 1'b0};
      `CRS_OFS_STATUS: r = {1'b0, 25'h0, s.halted, s.bus.resetAckB, s.amode, s.st};
      `CRS_OFS_PTR:    r = {1'b0, s.ptr};
      `CRS_OFS_PSW:    r = {1'b0, s.processor_status_word};
      `CRS_OFS_PC:     r = {1'b0, s.pc};
      `CRS_OFS_SP:     r = {1'b0, s.sp};
      default:         r = {1'b1, 32'h0};
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    // safe output state; arbiter drives control idle levels, else floats; address/data always floats
    idleBus = '{resetAckB: 1'b1, abortB: 1'b1, addrStrobeB: 1'b1, dataStrobeB: 1'b1,
                dataLatchedB: 1'b1, rwB: 1'b1, cycleInitB: 1'b1,
                accessStatusCode: `CRS_SAS_IDLE, transferSize: 3'h0,
                queueStatus: `CRS_QS_IDLE, instrStartB: 1'b1,
                virtualAddrFlagB: q.bus.virtualAddrFlagB, execModeOut: q.bus.execModeOut,
                busRequestLineB: 1'b1, ctlOeB: arbiterSelectB, adOeB: 1'b1};
    apbWr = psel && penable && pwrite && q.pready;
    swRst = apbWr && (paddr == `CRS_OFS_CTRL) && pwdata[`CRS_CTRL_SWRST];
    reqNow = !resetRequestInB;
    d.hist = {q.hist[1:0], reqNow};
    recog = &d.hist;
    stopNow = !stopInB;
    d.alignTrap = 1'b0;
    d.memReq = 1'b0;

    // apb answers one cycle into the access phase
    d.pready = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    rdRes = rdDecode(paddr, q);
    if (psel && penable && !q.pready) begin
      d.prdata = pwrite ? 32'h0 : rdRes[31:0];
      d.pslverr = rdRes[32];
    end
    if (apbWr && paddr == `CRS_OFS_CTRL) begin
      d.alignAny = pwdata[`CRS_CTRL_ALNANY];
    end

    // reset sequencer
    unique case (q.st)
      ST_ACK: begin
        if (!reqNow) begin
          d.st = ST_STRCH;
          d.cnt = 8'h0;
        end
      end
      ST_STRCH: begin
        if (reqNow) begin
          d.st = ST_ACK;
        end else if (q.cnt == 8'(STRETCH_CYC - 1)) begin
          d.st = ST_LDPTR;
          d.post = 7'h0;
          d.memAddr = `CRS_CTX_VECTOR;
        end else begin
          d.cnt = q.cnt + 8'h1;
        end
      end
      ST_LDPTR, ST_LDPSW, ST_LDPC, ST_LDSP: begin
        d.memReq = !memAck;
        if (q.post != 7'h7f) begin
          d.post = q.post + 7'h1;
        end
        if (memAck) begin
          unique case (q.st)
            ST_LDPTR: begin
              d.ptr = memRdata;
              d.memAddr = memRdata + `CRS_PSW_OFS;
              d.st = ST_LDPSW;
            end
            ST_LDPSW: begin
              d.processor_status_word = memRdata;
              d.memAddr = q.ptr + `CRS_PC_OFS;
              d.st = ST_LDPC;
            end
            ST_LDPC: begin
              d.pc = memRdata;
              d.memAddr = q.ptr + `CRS_SP_OFS;
              d.st = ST_LDSP;
            end
            default: begin
              d.sp = memRdata;
              d.st = ST_RUN;
              if (q.processor_status_word[`CRS_PSW_IBIT]) begin
                d.processor_status_word[`CRS_PSW_IBIT] = 1'b0;
                d.ptr = q.ptr + `CRS_PTR_STEP;
              end
            end
          endcase
        end
      end
      ST_RUN: begin
        if (q.post != 7'h7f) begin
          d.post = q.post + 7'h1;
        end
      end
      default: d.st = ST_ACK;
    endcase
    // internal and fault-induced resets skip straight to the stretch
    if (swRst || faultResetReq) begin
      d.st = ST_STRCH;
      d.cnt = 8'h0;
    end
    if (recog) begin
      d.st = ST_ACK;
    end

    // bus outputs
    d.bus = idleBus;
    if (d.st inside {ST_LDPTR, ST_LDPSW, ST_LDPC, ST_LDSP, ST_RUN}) begin
      d.bus.virtualAddrFlagB = (q.post >= 7'(`CRS_VAD_CYC)) ? 1'b1 : q.bus.virtualAddrFlagB;
      d.bus.execModeOut = (q.post >= 7'(`CRS_XMD_CYC)) ? `CRS_XMD_KERNEL : q.bus.execModeOut;
    end
    if (d.st == ST_ACK || d.st == ST_STRCH) begin
      d.bus.resetAckB = 1'b0;
      d.amode = AB_NONE;
      d.cs = 3'h0;
    end

    // transfer clock state tracking and abort
    csNext = coreReq.txnStart ? 3'h1 : ((q.cs != 3'h0 && q.cs != 3'h7) ? q.cs + 3'h1 : q.cs);
    if (q.st == ST_RUN && d.st == ST_RUN) begin
      d.cs = csNext;
      if (coreReq.txnStart) begin
        if (coreReq.discHit) begin
          d.amode = AB_DISC;
        end else if (coreReq.alignFault && !q.alignAny) begin
          d.amode = AB_ALIGN;
          d.alignTrap = 1'b1;
        end else begin
          d.amode = AB_NONE;
        end
      end else if (q.cs == 3'h7) begin
        d.amode = AB_NONE;
      end
      d.bus.virtualAddrFlagB = !coreReq.vadReq;
      d.bus.execModeOut = coreReq.xmdReq;
      d.bus.rwB = coreReq.rwReq;
      d.bus.cycleInitB = !coreReq.cycleInitReq;
      d.bus.accessStatusCode = coreReq.sasReq;
      d.bus.transferSize = coreReq.sizeReq;
      d.bus.queueStatus = coreReq.queueReq;
      d.bus.adOeB = arbiterSelectB;
      if (d.amode == AB_NONE) begin
        d.bus.addrStrobeB = !coreReq.addrStrobeReq;
        d.bus.dataStrobeB = !coreReq.dataStrobeReq;
        d.bus.dataLatchedB = !coreReq.dataLatchReq;
      end
      // abort for two clock states from state four or three
      if (d.amode == AB_DISC) begin
        d.bus.abortB = !(d.cs >= `CRS_ABT_DISC_CS && d.cs < `CRS_ABT_DISC_CS + `CRS_ABT_LEN);
      end
      if (d.amode == AB_ALIGN) begin
        d.bus.abortB = !(d.cs >= `CRS_ABT_ALIGN_CS && d.cs < `CRS_ABT_ALIGN_CS + `CRS_ABT_LEN);
      end
    end
    d.ackMask = (d.amode != AB_NONE);

    // stop handling; the last start before stop counts as the current
    // instruction, so a stepping controller that reacts late still gets one
    d.stopPrev = stopNow;
    if (!stopNow && q.stopPrev) begin
      d.spent = 1'b0;
    end
    if (!stopNow) begin
      d.halted = 1'b0;
    end
    d.soiPrev = 1'b0;
    if (q.st == ST_RUN && d.st == ST_RUN && coreReq.soiReq && !(stopNow && q.spent) && !q.soiPrev) begin
      d.bus.instrStartB = 1'b0;
      d.soiPrev = 1'b1;
      d.spent = 1'b1;
    end
    d.startAllowed = !(stopNow && d.spent);
    if (stopNow && d.spent && coreInstrDone && q.st == ST_RUN) begin
      d.halted = 1'b1;
    end
    // bus grants are not touched here, only interrupt service waits
    d.intAckOk = !stopNow && (d.st == ST_RUN);
    if (d.halted && d.st == ST_RUN && !arbiterSelectB && busGrantAckB) begin
      d.bus.accessStatusCode = `CRS_SAS_STOPACK;
    end
  end

  // ==========================================================
  // flops; reset behaves as an internal reset request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= ST_STRCH;
      q.bus <= '{resetAckB: 1'b0, abortB: 1'b1, addrStrobeB: 1'b1, dataStrobeB: 1'b1,
                 dataLatchedB: 1'b1, rwB: 1'b1, cycleInitB: 1'b1,
                 accessStatusCode: `CRS_SAS_IDLE, transferSize: 3'h0,
                 queueStatus: `CRS_QS_IDLE, instrStartB: 1'b1, virtualAddrFlagB: 1'b1,
                 execModeOut: `CRS_XMD_KERNEL, busRequestLineB: 1'b1, ctlOeB: arbiterSelectB, adOeB: 1'b1};
      q.startAllowed <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // checks
  property p_recog;
    @(posedge sys_clk) disable iff (!rst_b)
      (!resetRequestInB)[*3] |=> !busOut.resetAckB;
  endproperty
  a_recog: assert property (p_recog) else $error("reset not recognised after three latchings");

  property p_stretch;
    @(posedge sys_clk) disable iff (!rst_b)
      (q.st == ST_STRCH && q.cnt == 8'(STRETCH_CYC - 1) && resetRequestInB && !faultResetReq)
      |=> busOut.resetAckB && q.st == ST_LDPTR && memAddr == `CRS_CTX_VECTOR;
  endproperty
  a_stretch: assert property (p_stretch) else $error("acknowledge stretch end wrong");

  property p_ackHeld;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(resetRequestInB) && !busOut.resetAckB |-> !busOut.resetAckB[*8];
  endproperty
  a_ackHeld: assert property (p_ackHeld) else $error("acknowledge dropped early");

  property p_pcAddr;
    @(posedge sys_clk) disable iff (!rst_b)
      (q.st == ST_LDPSW && memAck && !resetRequestInB == 1'b0) |=> memAddr == q.ptr + `CRS_PC_OFS;
  endproperty
  a_pcAddr: assert property (p_pcAddr) else $error("pc fetch address wrong");

  property p_iBit;
    @(posedge sys_clk) disable iff (!rst_b)
      (q.st == ST_LDSP && memAck && q.processor_status_word[`CRS_PSW_IBIT] && resetRequestInB && !faultResetReq)
      |=> !q.processor_status_word[`CRS_PSW_IBIT] && q.ptr == $past(q.ptr) + `CRS_PTR_STEP;
  endproperty
  a_iBit: assert property (p_iBit) else $error("initial context adjust wrong");

  property p_discAbort;
    @(posedge sys_clk) disable iff (!rst_b || !resetRequestInB || faultResetReq)
      (q.st == ST_RUN && coreReq.txnStart && coreReq.discHit)
      |-> ##1 busOut.abortB[*3] ##1 !busOut.abortB[*2] ##1 busOut.abortB;
  endproperty
  a_discAbort: assert property (p_discAbort) else $error("discontinuity abort timing wrong");

  property p_alignAbort;
    @(posedge sys_clk) disable iff (!rst_b || !resetRequestInB || faultResetReq)
      (q.st == ST_RUN && coreReq.txnStart && !coreReq.discHit && coreReq.alignFault && !q.alignAny)
      |-> ##1 alignTrap ##2 !busOut.abortB;
  endproperty
  a_alignAbort: assert property (p_alignAbort) else $error("alignment abort timing wrong");

  property p_noStrobe;
    @(posedge sys_clk) disable iff (!rst_b)
      ackMask |-> busOut.addrStrobeB && busOut.dataStrobeB && busOut.dataLatchedB;
  endproperty
  a_noStrobe: assert property (p_noStrobe) else $error("strobe during aborted transfer");

  property p_soiPulse;
    @(posedge sys_clk) disable iff (!rst_b)
      !busOut.instrStartB |=> busOut.instrStartB;
  endproperty
  a_soiPulse: assert property (p_soiPulse) else $error("start pulse longer than one cycle");

  property p_armReset;
    @(posedge sys_clk) disable iff (!rst_b)
      !busOut.resetAckB && !arbiterSelectB |-> busOut.accessStatusCode == `CRS_SAS_IDLE
        && busOut.transferSize == 3'h0 && busOut.adOeB && !busOut.ctlOeB;
  endproperty
  a_armReset: assert property (p_armReset) else $error("reset output state wrong");
endmodule

// ===== test/cpu_reset_abort_step_control_bench.sv
// Purpose: self-checking bench of the reset, abort and stop controller
// Assumes: short stretch parameter, slow context memory
// Notes:   inputs change at rising edges, outputs sampled 1 ns later
`timescale 1ns/1ps
`include "crs_params.svh"
module cpu_reset_abort_step_control_bench import crs_pkg::*;;
  localparam int STR = 8;
  logic        clk, rstB, psel, penable, pwrite, pready, pslverr;
  logic        resetRequestInB, faultResetReq, arbiterSelectB, busGrantAckB, stopInB;
  logic        coreInstrDone, startAllowed, intAckOk, ackMask, alignTrap, coreRun;
  logic        memAck, memReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ctxPc, memRdata, memAddr, rd;
  logic        err;
  crs_core_s   coreReq;
  crs_bus_s    busOut;
  int          miscompares, checked, k;
  logic [7:0]  ab, tr;
  // ==========================================================
  // design and far side
  crs_top #(.STRETCH_CYC(STR)) dut (.sys_clk(clk), .rst_b(rstB), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resetRequestInB(resetRequestInB), .faultResetReq(faultResetReq),
    .arbiterSelectB(arbiterSelectB), .busGrantAckB(busGrantAckB), .stopInB(stopInB),
    .busOut(busOut), .coreReq(coreReq), .coreInstrDone(coreInstrDone),
    .startAllowed(startAllowed), .intAckOk(intAckOk), .ackMask(ackMask), .alignTrap(alignTrap),
    .coreRun(coreRun), .ctxPc(ctxPc), .memAck(memAck), .memRdata(memRdata), .memReq(memReq),
    .memAddr(memAddr));
  crs_mem_model #(.DLY(2)) mem (.sys_clk(clk), .memReq(memReq), .memAddr(memAddr),
    .memAck(memAck), .memRdata(memRdata));
  // ==========================================================
  // shared tasks
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang();
    miscompares++;
    report_and_stop();
  endtask
  // apb master, holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_run();
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (coreRun !== 1'b1 && k < 400);
    if (k >= 400) hang();
  endtask
  // counts cycles until acknowledge rises
  task automatic ack_len(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (busOut.resetAckB !== 1'b1 && n < 400);
    if (n >= 400) hang();
  endtask
  // ==========================================================
  // scenarios
  task automatic t_powerup();
    int n;
    #1 chk({busOut.addrStrobeB, busOut.dataStrobeB, busOut.accessStatusCode}, 6'h3f);
    chk({busOut.transferSize, busOut.adOeB, busOut.resetAckB}, 5'h02);
    ack_len(n);
    repeat (70) @(posedge clk);
    #1 chk({busOut.virtualAddrFlagB, busOut.execModeOut}, 3'h4);
    wait_run();
    apb(1'b0, `CRS_OFS_PTR, 32'h0);
    chk(rd, 32'h0000_040c);
    apb(1'b0, `CRS_OFS_PSW, 32'h0);
    chk(rd, 32'h0000_00a0);
    apb(1'b0, `CRS_OFS_PC, 32'h0);
    chk(rd, 32'h0000_1000);
    apb(1'b0, `CRS_OFS_SP, 32'h0);
    chk(rd, 32'h0000_2000);
    chk(ctxPc, 32'h0000_1000);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_abort(input logic align);
    @(posedge clk);
    coreReq.txnStart <= 1'b1;
    coreReq.discHit <= !align;
    coreReq.alignFault <= align;
    coreReq.addrStrobeReq <= 1'b1;
    coreReq.dataStrobeReq <= 1'b1;
    ab = 8'h0;
    tr = 8'h0;
    for (int i = 1; i < 8; i++) begin
      @(posedge clk);
      coreReq.txnStart <= 1'b0;
      #1 ab[i] = !busOut.abortB;
      tr[i] = alignTrap | !busOut.addrStrobeB | !busOut.dataStrobeB | !busOut.dataLatchedB;
    end
    @(posedge clk);
    coreReq <= '0;
    chk(ab, align ? 8'h18 : 8'h30);
    chk(tr, align ? 8'h02 : 8'h00);
  endtask
  task automatic t_stop();
    logic [31:0] n;
    @(posedge clk);
    coreReq.soiReq <= 1'b1;
    coreReq.sasReq <= 4'h5;
    @(posedge clk);
    coreReq.soiReq <= 1'b0;
    n = 32'h0;
    repeat (5) begin
      #1 n = n + 32'(!busOut.instrStartB);
      @(posedge clk);
    end
    chk(n, 32'h1);
    stopInB <= 1'b0;
    coreInstrDone <= 1'b1;
    busGrantAckB <= 1'b1;
    coreReq.soiReq <= 1'b1;
    n = 32'h0;
    repeat (6) begin
      #1 n = n + 32'(!busOut.instrStartB);
      @(posedge clk);
    end
    chk(n, 32'h0);
    #1 chk({busOut.accessStatusCode, intAckOk, startAllowed}, 6'h00);
    // single step: release until a start pulse, then stop again at once
    @(posedge clk);
    stopInB <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (busOut.instrStartB !== 1'b0 && k < 20);
    if (k >= 20) hang();
    @(posedge clk);
    stopInB <= 1'b0;
    n = 32'h0;
    repeat (6) begin
      #1 n = n + 32'(!busOut.instrStartB);
      @(posedge clk);
    end
    chk(n, 32'h0);
    #1 chk(busOut.accessStatusCode, 4'h0);
    @(posedge clk);
    stopInB <= 1'b1;
    coreReq <= '0;
    repeat (5) @(posedge clk);
    #1 chk(intAckOk, 1'b1);
  endtask
  task automatic t_sysreset();
    int n;
    @(posedge clk);
    resetRequestInB <= 1'b0;
    repeat (2) @(posedge clk);
    resetRequestInB <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(busOut.resetAckB, 1'b1);
    @(posedge clk);
    resetRequestInB <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({busOut.resetAckB, busOut.addrStrobeB, busOut.adOeB}, 3'h3);
    @(posedge clk);
    resetRequestInB <= 1'b1;
    repeat (4) @(posedge clk);
    resetRequestInB <= 1'b0;
    @(posedge clk);
    resetRequestInB <= 1'b1;
    ack_len(n);
    chk(n, STR + 1);
    wait_run();
  endtask
  task automatic t_intreset(input logic fault);
    int n;
    if (fault) begin
      @(posedge clk);
      faultResetReq <= 1'b1;
      @(posedge clk);
      faultResetReq <= 1'b0;
    end else begin
      apb(1'b1, `CRS_OFS_CTRL, 32'h1);
    end
    repeat (2) @(posedge clk);
    #1 chk(busOut.resetAckB, 1'b0);
    ack_len(n);
    chk(n >= STR - 2 && n <= STR + 1, 1'b1);
    wait_run();
    chk(memAddr, 32'h0000_0408);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    miscompares = 0;
    checked = 0;
    rstB = 1'b0;
    {psel, penable, pwrite, faultResetReq, arbiterSelectB, coreInstrDone} = 6'h0;
    {resetRequestInB, busGrantAckB, stopInB} = 3'h7;
    paddr = 12'h0;
    pwdata = 32'h0;
    coreReq = '0;
    repeat (12) @(posedge clk);
    rstB <= 1'b1;
    t_powerup();
    t_abort(1'b0);
    t_abort(1'b1);
    t_stop();
    t_sysreset();
    t_intreset(1'b0);
    t_intreset(1'b1);
    report_and_stop();
  end
endmodule

// ===== test/crs_mem_model.sv
// Purpose: context memory on the far side of the fetch port
// Assumes: one word per request, answer after DLY cycles
// Notes:   data line scrambled outside answers
`timescale 1ns/1ps
module crs_mem_model #(
  parameter int DLY = 2
) (
  // clock
  input  wire logic        sys_clk,
  // fetch port
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  // ==========================================================
  // reset control block image
  logic [3:0] waitQ;
  logic       doneQ;
  function automatic logic [31:0] word(input logic [31:0] a);
    case (a)
      32'h0000_0080: word = 32'h0000_0400;
      32'h0000_0400: word = 32'h0000_00a1; // initial-context bit set
      32'h0000_0404: word = 32'h0000_1000;
      32'h0000_0408: word = 32'h0000_2000;
      default:       word = 32'hbad0_0000;
    endcase
  endfunction
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0;
    waitQ = 4'h0;
    doneQ = 1'b0;
  end
  // one answer per request; stale data never left on the line
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (!memReq) begin
      doneQ <= 1'b0;
      waitQ <= 4'h0;
    end else if (!doneQ && !memAck) begin
      if (waitQ == DLY[3:0]) begin
        memAck <= 1'b1;
        memRdata <= word(memAddr);
        doneQ <= 1'b1;
      end else begin
        waitQ <= waitQ + 4'h1;
      end
    end
  end
endmodule
